// File: tcsl_loader.sv
/*
 Settings loader top: copies the coefficient store into system registers
 after reset, arbitrates host accesses, produces output registers and pins.
 Assumes raw rate and temperature samples arrive synchronous to sys_clk,
 and that the host writes only once loadBusy has dropped.
*/
// What this block does
// - Gain and offset written only to system registers act on the temperature output at once.
// - Committed calibration stores select = 1 and takes effect only after the next reset.
// - After reset all stored settings are copied into system registers before any output.
// - One controller arbitrates between output registers, system registers and the store.
// - Rate and temperature results sit in output registers rateOut and tempOut; host reads return system registers only.
// - A data-ready pin flags new output and a self-check pin carries the self-test function.
// - Power-on reset or the active-low external reset restarts and reloads the store.
// - Deasserting enable puts the sensor into power-down.
// - Samples are decimated and the rate is compensated by subtracting the rateComp input.
// - Calibrated mode outputs gain times raw minus offset at 85 LSB per degree.
// - Select at 0 outputs raw temperature, as the host needs while calibrating.
`timescale 1ns/1ps
`default_nettype none
module tcsl_loader
    import tcsl_pkg::*;
(
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic external_reset_pin_n,
    input wire logic enable,
    input wire logic self_check_pin,
    input wire logic sampleValid,
    input wire logic [TCSL_WORD_W-1:0] rawRate,
    input wire logic [TCSL_WORD_W-1:0] rawTemp,
    input wire logic [TCSL_WORD_W-1:0] rateComp,
    input wire logic sysWrite,
    input wire logic storeWrite,
    input wire logic [TCSL_ADDR_W-1:0] hostAddr,
    input wire logic [TCSL_WORD_W-1:0] hostData,
    output logic [TCSL_WORD_W-1:0] sysReadData,
    output logic [TCSL_WORD_W-1:0] rateOut,
    output logic [TCSL_WORD_W-1:0] tempOut,
    output logic new_sample_pin,
    output logic selfCheckActive,
    output logic powerDown,
    output logic loadBusy
);
    logic [TCSL_WORD_W-1:0] rewritable_coeff_store [TCSL_STORE_DEPTH];
    logic [TCSL_WORD_W-1:0] sysReg [TCSL_STORE_DEPTH];
    tcsl_state_t state;
    logic [TCSL_ADDR_W-1:0] loadAddr;
    logic restart;
    logic [2:0] decimCount;
    logic step;
    logic calSelect;
    // eight samples need more bits than one, or the sum wraps
    localparam int TCSL_ACC_W = TCSL_WORD_W + $clog2(TCSL_DECIM);
    logic [TCSL_ACC_W-1:0] rateAcc;
    logic [TCSL_ACC_W-1:0] rateSum;

    assign restart = srst | ~external_reset_pin_n;
    assign calSelect = sysReg[TCSL_ADDR_CTRL][TCSL_CTRL_TSEL_BIT];
    assign loadBusy = (state != TCSL_RUN);
    assign powerDown = ~enable;
    assign selfCheckActive = self_check_pin & enable;

    // store writes only; contents survive restart
    always_ff @(posedge sys_clk) begin
        if (!restart && storeWrite && state == TCSL_RUN) begin
            rewritable_coeff_store[hostAddr] <= hostData;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (restart) begin
            state <= TCSL_IDLE;
            loadAddr <= TCSL_ADDR_GAIN;
        end else begin
            case (state)
                TCSL_IDLE: begin
                    state <= TCSL_LOAD;
                    loadAddr <= TCSL_ADDR_GAIN;
                end
                TCSL_LOAD: begin
                    loadAddr <= loadAddr + 4'h1;
                    if (loadAddr == TCSL_ADDR_LAST) begin
                        state <= TCSL_RUN;
                    end
                end
                TCSL_RUN: state <= TCSL_RUN;
                default: state <= TCSL_IDLE;
            endcase
        end
    end

    // copy store into system registers, then host writes act directly
    always_ff @(posedge sys_clk) begin
        if (!restart && state == TCSL_LOAD) begin
            sysReg[loadAddr] <= rewritable_coeff_store[loadAddr];
        end else if (!restart && state == TCSL_RUN && sysWrite) begin
            sysReg[hostAddr] <= hostData;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (restart) begin
            sysReadData <= TCSL_ZERO;
        end else begin
            sysReadData <= sysReg[hostAddr];
        end
    end

    // decimation counter gives the output enable
    always_ff @(posedge sys_clk) begin
        if (restart || state != TCSL_RUN || !enable) begin
            decimCount <= 3'h0;
            rateAcc <= '0;
        end else if (sampleValid) begin
            decimCount <= decimCount + 3'h1;
            rateAcc <= (decimCount == TCSL_DECIM_LAST) ? '0 : rateSum;
        end
    end
    assign rateSum = rateAcc + TCSL_ACC_W'(rawRate);
    assign step = sampleValid && enable && state == TCSL_RUN && decimCount == TCSL_DECIM_LAST;

    always_ff @(posedge sys_clk) begin
        if (restart) begin
            new_sample_pin <= 1'b0;
        end else begin
            new_sample_pin <= step;
        end
    end

    // average of eight: top word of the wide sum
    always_ff @(posedge sys_clk) begin
        if (restart) begin
            rateOut <= TCSL_ZERO;
        end else if (step) begin
            rateOut <= rateSum[TCSL_ACC_W-1 -: TCSL_WORD_W] - rateComp;
        end
    end

    tcsl_temp_cal u_cal (
        .sys_clk(sys_clk),
        .srst(restart),
        .step(step),
        .calSelect(calSelect),
        .gain(sysReg[TCSL_ADDR_GAIN]),
        .offset(sysReg[TCSL_ADDR_OFFSET]),
        .rawTemp(rawTemp),
        .tempOut(tempOut)
    );

    // no output until the reload is over, none while powered down
    ready_after_load_a: assert property (@(posedge sys_clk) disable iff (restart)
        new_sample_pin |-> !loadBusy) else $error("data ready during load");
    load_no_step_a: assert property (@(posedge sys_clk) disable iff (restart)
        loadBusy |-> !step)
        else $error("output step during load");
    power_down_a: assert property (@(posedge sys_clk) disable iff (restart)
        !enable |=> !new_sample_pin) else $error("output while powered down");
    power_step_a: assert property (@(posedge sys_clk) disable iff (restart)
        powerDown |-> !step)
        else $error("output step while powered down");
    sleep_count_a: assert property (@(posedge sys_clk) disable iff (restart)
        !enable |=> decimCount == '0)
        else $error("sample count kept in power down");
    pin_needs_enable_a: assert property (@(posedge sys_clk) disable iff (restart)
        new_sample_pin |-> $past(enable))
        else $error("data ready after disabled cycle");
    self_check_a: assert property (@(posedge sys_clk) disable iff (restart)
        !enable |-> !selfCheckActive)
        else $error("self test while powered down");
    ready_pulse_a: assert property (@(posedge sys_clk) disable iff (restart)
        step |=> new_sample_pin) else $error("missing data ready");

    // reset and reload sequence
    reset_reload_a: assert property (@(posedge sys_clk)
        !external_reset_pin_n |=> loadBusy) else $error("pin reset ignored");
    busy_after_reset_a: assert property (@(posedge sys_clk)
        restart |=> loadBusy && !new_sample_pin)
        else $error("reset did not restart the load");
    reset_outputs_a: assert property (@(posedge sys_clk)
        restart |=> rateOut == TCSL_ZERO && tempOut == TCSL_ZERO)
        else $error("outputs not cleared by reset");
    idle_to_load_a: assert property (@(posedge sys_clk) disable iff (restart)
        state == TCSL_IDLE |=> state == TCSL_LOAD)
        else $error("reload did not start");
    load_start_a: assert property (@(posedge sys_clk) disable iff (restart)
        $rose(state == TCSL_LOAD) |-> loadAddr == TCSL_ADDR_GAIN)
        else $error("reload not from first word");
    load_stays_a: assert property (@(posedge sys_clk) disable iff (restart)
        state == TCSL_LOAD && loadAddr != TCSL_ADDR_LAST |=> state == TCSL_LOAD)
        else $error("reload left early");
    load_to_run_a: assert property (@(posedge sys_clk) disable iff (restart)
        state == TCSL_LOAD && loadAddr == TCSL_ADDR_LAST |=> state == TCSL_RUN)
        else $error("reload did not finish");
    load_length_a: assert property (@(posedge sys_clk) disable iff (restart)
        $rose(state == TCSL_LOAD) |-> ##16 (state == TCSL_RUN))
        else $error("load not sixteen cycles");

    // data path
    raw_mode_a: assert property (@(posedge sys_clk) disable iff (restart)
        step && !calSelect |=> tempOut == $past(rawTemp)) else $error("raw temp wrong");
    temp_hold_a: assert property (@(posedge sys_clk) disable iff (restart)
        !$past(step) && !$past(restart) |-> $stable(tempOut))
        else $error("temperature moved");
    rate_hold_a: assert property (@(posedge sys_clk) disable iff (restart)
        !new_sample_pin && !$past(step) && !$past(restart) |-> $stable(rateOut))
        else $error("rate moved");
    decim_restart_a: assert property (@(posedge sys_clk) disable iff (restart)
        step |=> decimCount == '0)
        else $error("sample count not restarted");
    decim_hold_a: assert property (@(posedge sys_clk) disable iff (restart)
        !sampleValid && enable && state == TCSL_RUN |=> $stable(decimCount))
        else $error("sample count moved without sample");
    sys_write_a: assert property (@(posedge sys_clk) disable iff (restart)
        sysWrite && !loadBusy |=> sysReg[$past(hostAddr)] == $past(hostData))
        else $error("system write lost");

    load_done_c: cover property (@(posedge sys_clk) $fell(loadBusy));
    cal_sample_c: cover property (@(posedge sys_clk) step && calSelect);
    raw_sample_c: cover property (@(posedge sys_clk) step && !calSelect);
    pin_reset_c: cover property (@(posedge sys_clk) $fell(external_reset_pin_n));
    host_write_c: cover property (@(posedge sys_clk) sysWrite && !loadBusy);
endmodule : tcsl_loader
`default_nettype wire

// File: tcsl_pkg.sv
/*
 Constants shared by the settings and calibration loader: store layout,
 fixed-point scaling, timing. Assumes a 25 MHz system clock.
*/
package tcsl_pkg;
    localparam int TCSL_WORD_W = 24;
    localparam int TCSL_STORE_DEPTH = 16;
    localparam int TCSL_ADDR_W = 4;
    localparam logic [TCSL_ADDR_W-1:0] TCSL_ADDR_GAIN = 4'h0;
    localparam logic [TCSL_ADDR_W-1:0] TCSL_ADDR_OFFSET = 4'h1;
    localparam logic [TCSL_ADDR_W-1:0] TCSL_ADDR_CTRL = 4'h2;
    localparam logic [TCSL_ADDR_W-1:0] TCSL_ADDR_LAST = 4'hF;
    localparam int TCSL_CTRL_TSEL_BIT = 0;
    localparam int TCSL_GAIN_FRAC = 11;
    localparam logic [TCSL_WORD_W-1:0] TCSL_GAIN_UNITY = 24'h000800;
    localparam logic [TCSL_WORD_W-1:0] TCSL_ZERO = 24'h000000;
    localparam int TCSL_DEG_LSB = 85;
    localparam int TCSL_CLK_MHZ = 25;
    localparam int TCSL_DECIM = 8;
    localparam logic [2:0] TCSL_DECIM_LAST = 3'h7;
    typedef enum {TCSL_IDLE, TCSL_LOAD, TCSL_RUN} tcsl_state_t;
endpackage : tcsl_pkg

// File: tcsl_temp_cal.sv
/*
 Calibrated temperature path: gain * raw >> 11 minus offset, or raw passthrough.
 Assumes the caller steps it with a one-cycle enable.
*/
`timescale 1ns/1ps
`default_nettype none
module tcsl_temp_cal
    import tcsl_pkg::*;
(
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic step,
    input wire logic calSelect,
    input wire logic [TCSL_WORD_W-1:0] gain,
    input wire logic [TCSL_WORD_W-1:0] offset,
    input wire logic [TCSL_WORD_W-1:0] rawTemp,
    output logic [TCSL_WORD_W-1:0] tempOut
);
    logic [2*TCSL_WORD_W-1:0] product;
    logic [TCSL_WORD_W-1:0] scaled;

    assign product = gain * rawTemp;
    assign scaled = product[TCSL_GAIN_FRAC +: TCSL_WORD_W];

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            tempOut <= TCSL_ZERO;
        end else if (step) begin
            tempOut <= calSelect ? (scaled - offset) : rawTemp;
        end
    end
endmodule : tcsl_temp_cal
`default_nettype wire

// File: tcsl_host_model.sv
/* Host side model: system register writes, store commits, readback.
   Assumes calls only while the loader is in run state. */
`timescale 1ns/1ps
`default_nettype none
module tcsl_host_model
    import tcsl_pkg::*;
(
    input wire logic sys_clk,
    input wire logic [TCSL_WORD_W-1:0] sysReadData,
    output logic sysWrite,
    output logic storeWrite,
    output logic [TCSL_ADDR_W-1:0] hostAddr,
    output logic [TCSL_WORD_W-1:0] hostData
);
    initial begin
        sysWrite = 1'b0;
        storeWrite = 1'b0;
        hostAddr = 4'h0;
        hostData = 24'h000000;
    end
    // gain arrives pre-scaled by 2^11, commits carry select 1
    task automatic put(input logic toStore, input logic [3:0] a, input logic [23:0] d);
        @(posedge sys_clk);
        #1;
        sysWrite = ~toStore;
        storeWrite = toStore;
        hostAddr = a;
        hostData = d;
        @(posedge sys_clk);
        #1;
        sysWrite = 1'b0;
        storeWrite = 1'b0;
        hostData = ~d;
    endtask : put
    task automatic look(input logic [3:0] a, output logic [23:0] d);
        @(posedge sys_clk);
        #1;
        hostAddr = a;
        @(posedge sys_clk);
        #1;
        d = sysReadData;
    endtask : look
endmodule : tcsl_host_model
`default_nettype wire

// File: temp_calib_settings_loader_bench.sv
/* Self-checking bench for the loader with random samples.
   Assumes the store keeps its contents across reset. */
`timescale 1ns/1ps
`default_nettype none
module temp_calib_settings_loader_bench
    import tcsl_pkg::*;
;
    logic sys_clk, srst, external_reset_pin_n, enable, self_check_pin, sampleValid;
    logic sysWrite, storeWrite, new_sample_pin, selfCheckActive, powerDown, loadBusy;
    logic [3:0] hostAddr;
    logic [23:0] rawRate, rawTemp, rateComp, hostData, sysReadData, rateOut, tempOut, g, o, rd;
    int miscompares = 0;
    int check_count = 0;
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    tcsl_loader tcsl_loader_inst(.sys_clk(sys_clk), .srst(srst),
        .external_reset_pin_n(external_reset_pin_n), .enable(enable),
        .self_check_pin(self_check_pin), .sampleValid(sampleValid), .rawRate(rawRate),
        .rawTemp(rawTemp), .rateComp(rateComp), .sysWrite(sysWrite), .storeWrite(storeWrite),
        .hostAddr(hostAddr), .hostData(hostData), .sysReadData(sysReadData),
        .rateOut(rateOut), .tempOut(tempOut), .new_sample_pin(new_sample_pin),
        .selfCheckActive(selfCheckActive), .powerDown(powerDown), .loadBusy(loadBusy));
    tcsl_host_model tcsl_host_model_inst(.sys_clk(sys_clk), .sysReadData(sysReadData),
        .sysWrite(sysWrite), .storeWrite(storeWrite), .hostAddr(hostAddr), .hostData(hostData));
    task automatic check(input string n, input logic [23:0] e, input logic [23:0] s);
        check_count++;
        if (s !== e) begin
            $display("ERROR %s expected %h seen %h", n, e, s);
            miscompares++;
        end
    endtask : check
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : report_and_stop
    task automatic do_reset(input logic viaPin, input int n);
        int k;
        @(posedge sys_clk);
        #1;
        if (viaPin) external_reset_pin_n = 1'b0;
        else srst = 1'b1;
        repeat (n) @(posedge sys_clk);
        #1;
        srst = 1'b0;
        external_reset_pin_n = 1'b1;
        for (k = 0; loadBusy !== 1'b0; k++) begin
            check("pin in load", 24'h0, 24'(new_sample_pin));
            if (k > 40) begin
                $display("ERROR load wait expected done seen busy after %0d cycles", k);
                miscompares++;
                report_and_stop();
            end
            @(posedge sys_clk);
            #1;
        end
    endtask : do_reset
    task automatic burst(input logic cal, input logic [23:0] gn, input logic [23:0] of);
        logic [26:0] sum;
        logic [47:0] p;
        int k;
        sum = 27'h0;
        rateComp = 24'($urandom);
        for (k = 0; k < 8; k++) begin
            @(posedge sys_clk);
            #1;
            sampleValid = 1'b1;
            rawRate = 24'($urandom);
            rawTemp = 24'($urandom) & 24'h00FFFF;
            sum = sum + 27'(rawRate);
        end
        @(posedge sys_clk);
        #1;
        sampleValid = 1'b0;
        for (k = 0; new_sample_pin !== 1'b1 && k < 4; k++) begin
            @(posedge sys_clk);
            #1;
        end
        check("pin", 24'h1, 24'(new_sample_pin));
        p = gn * rawTemp;
        check("temp", cal ? p[34:11] - of : rawTemp, tempOut);
        check("rate", sum[26:3] - rateComp, rateOut);
        @(posedge sys_clk);
        #1;
        check("pin pulse", 24'h0, 24'(new_sample_pin));
    endtask : burst
    initial begin
        {srst, external_reset_pin_n, enable, self_check_pin, sampleValid} = 5'h1A;
        {rawRate, rawTemp, rateComp} = 72'h0;
        void'($urandom(32781));
        do_reset(1'b0, 10);
        g = 24'h000800 + (24'($urandom) & 24'h0007FF);
        o = 24'($urandom) & 24'h0000FF;
        tcsl_host_model_inst.put(1'b1, TCSL_ADDR_GAIN, g);
        tcsl_host_model_inst.put(1'b1, TCSL_ADDR_OFFSET, o);
        tcsl_host_model_inst.put(1'b1, TCSL_ADDR_CTRL, 24'h000001);
        do_reset(1'b1, 2);
        tcsl_host_model_inst.look(TCSL_ADDR_GAIN, rd);
        check("gain reload", g, rd);
        self_check_pin = 1'b1;
        enable = 1'b0;
        #1;
        check("power down", 24'h1, 24'(powerDown));
        check("self test off", 24'h0, 24'(selfCheckActive));
        @(posedge sys_clk);
        #1;
        enable = 1'b1;
        #1;
        check("self test", 24'h1, 24'(selfCheckActive));
        check("power up", 24'h0, 24'(powerDown));
        repeat (3) burst(1'b1, g, o);
        rd = 24'($urandom) & 24'h000FFF;
        tcsl_host_model_inst.put(1'b0, TCSL_ADDR_GAIN, rd);
        burst(1'b1, rd, o);
        tcsl_host_model_inst.put(1'b0, TCSL_ADDR_CTRL, 24'h000000);
        burst(1'b0, g, o);
        do_reset(1'b0, 1);
        tcsl_host_model_inst.look(TCSL_ADDR_GAIN, rd);
        check("gain after reset", g, rd);
        burst(1'b1, g, o);
        report_and_stop();
    end
endmodule : temp_calib_settings_loader_bench
`default_nettype wire
